// ---- src/fsr_pkg.sv ----
package fsr_pkg;

    // Register map, byte addresses on the bus
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam logic [15:0] FN_STATE_ADDR = 16'h5b30;
    localparam logic [15:0] IRQ_STAT_ADDR = 16'h5b34;
    localparam logic [15:0] IRQ_MASK_ADDR = 16'h5b38;

    // Field positions of function_state_to_mgmt
    localparam int unsigned BIT_CHANGE   = 31;
    localparam int unsigned BIT_SWAP     = 30;
    localparam int unsigned BIT_CLKGATE  = 29;
    localparam int unsigned BIT_RSVD     = 28;
    localparam int unsigned BIT_AUX4     = 27;
    localparam int unsigned BIT_HMI_EN   = 26;
    localparam int unsigned LSB_FN4_LVL  = 24;
    localparam int unsigned FN4_INDEX    = 4;

    // Interrupt status and mask layout
    localparam int unsigned IRQ_W          = 1;
    localparam int unsigned IRQ_BIT_CHANGE = 0;
    localparam logic [0:0]  IRQ_MASK_RESET = 1'h0;

    // Configuration load
    localparam logic [7:0] NVM_SWAP_WORD = 8'h21;
    localparam logic [7:0] NVM_HMI_WORD  = 8'h49;
    localparam logic [3:0] NVM_SWAP_BIT  = 4'h0;
    localparam logic [3:0] NVM_HMI_BIT   = 4'h0;

    // Hold-off after clear on read
    localparam int unsigned HOLD_CYCLES = 8;
    localparam int unsigned HOLD_W      = 4;

    // Reset values of loaded fields
    localparam logic SWAP_RESET = 1'b0;
    localparam logic HMI_RESET  = 1'b0;

endpackage : fsr_pkg

// ---- src/fsr_route.sv ----
`timescale 1ns/1ns
module fsr_route
(
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic port0Enable,
    input  wire logic port1Enable,
    input  wire logic swapSelect,
    output logic      port0Function,
    output logic      port1Function,
    output logic      port0Routed,
    output logic      port1Routed
);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            port0Function <= 1'b0;
            port1Function <= 1'b0;
            port0Routed   <= 1'b0;
            port1Routed   <= 1'b0;
        end
        else
        begin
            port0Routed <= port0Enable;
            port1Routed <= port1Enable;
            if (port0Enable && port1Enable)
            begin
                port0Function <= swapSelect;
                port1Function <= !swapSelect;
            end
            else
            begin
                // Lone port lands on function 0
                port0Function <= 1'b0;
                port1Function <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_route_straight: assert property (
        port0Enable && port1Enable && !swapSelect
        |=> !port0Function && port1Function && port0Routed)
        else $error("straight routing wrong");

    a_route_swapped: assert property (
        port0Enable && port1Enable && swapSelect
        |=> port0Function && !port1Function && port1Routed)
        else $error("swapped routing wrong");

    a_route_single: assert property (
        !(port0Enable && port1Enable)
        |=> !port0Function && !port1Function)
        else $error("single port not on function 0");

endmodule : fsr_route

// ---- src/fsr_top.sv ----
`timescale 1ns/1ns
module fsr_top
#(
    parameter int unsigned NUM_FN = 5
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [15:0]           wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic [2*NUM_FN-1:0]   fnPowerLevel,
    input  wire logic                  mgmtClockGated,
    input  wire logic                  fn4AuxPowerShadow,
    input  wire logic                  port0Enable,
    input  wire logic                  port1Enable,
    input  wire logic                  nvmLoadValid,
    input  wire logic [7:0]            nvmLoadAddr,
    input  wire logic [15:0]           nvmLoadData,
    output logic                       powerChangeFlag,
    output logic                       irq,
    output logic                       port0Function,
    output logic                       port1Function,
    output logic                       port0Routed,
    output logic                       port1Routed
);

    logic                         busReq;
    logic                         readStrobe;
    logic                         writeStrobe;
    logic                         statusRead;
    logic [2*NUM_FN-1:0]          prevLevel;
    logic                         primed;
    logic [NUM_FN-1:0]            fnDiff;
    logic                         changeEvent;
    logic                         changePending;
    logic [fsr_pkg::HOLD_W-1:0]   holdCount;
    logic                         holdActive;
    logic                         portSwapSelect;
    logic                         hostMgmtFnEnable;
    logic [fsr_pkg::IRQ_W-1:0]    irqStatus;
    logic [fsr_pkg::IRQ_W-1:0]    irqMask;
    logic [fsr_pkg::IRQ_W-1:0]    irqEvents;
    logic [31:0]                  statusWord;
    logic [31:0]                  next_readData;

    // Bus strobes, one per classic cycle
    assign busReq      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign readStrobe  = busReq && !wb_we_i;
    assign writeStrobe = busReq && wb_we_i;
    assign statusRead  = readStrobe
                         && (wb_adr_i == fsr_pkg::FN_STATE_ADDR);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= busReq;
    end

    // Power level change detection
    genvar g;
    generate
        for (g = 0; g < NUM_FN; g++)
        begin : gen_fn
            assign fnDiff[g] = fnPowerLevel[2*g +: 2]
                               != prevLevel[2*g +: 2];
        end
    endgenerate

    // First sample after reset is a baseline, not a change
    assign changeEvent = primed && (|fnDiff);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            prevLevel <= '0;
            primed    <= 1'b0;
        end
        else
        begin
            prevLevel <= fnPowerLevel;
            primed    <= 1'b1;
        end
    end

    assign holdActive = (holdCount != '0);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            holdCount <= '0;
        else if (statusRead)
            holdCount <= fsr_pkg::HOLD_W'(fsr_pkg::HOLD_CYCLES);
        else if (holdActive)
            holdCount <= holdCount - 1'b1;
    end

    // Changes during hold-off are remembered, not lost
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            changePending <= 1'b0;
        else if (changeEvent && (statusRead || holdActive))
            changePending <= 1'b1;
        else if (!holdActive && !statusRead)
            changePending <= 1'b0;
    end

    // Read clear beats a new change: the hold-off demands it
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            powerChangeFlag <= 1'b0;
        else if (statusRead)
            powerChangeFlag <= 1'b0;
        else if (!holdActive && (changeEvent || changePending))
            powerChangeFlag <= 1'b1;
    end

    // Loaded configuration; status writes never reach it
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            portSwapSelect   <= fsr_pkg::SWAP_RESET;
            hostMgmtFnEnable <= fsr_pkg::HMI_RESET;
        end
        else if (nvmLoadValid)
        begin
            if (nvmLoadAddr == fsr_pkg::NVM_SWAP_WORD)
                portSwapSelect <= nvmLoadData[fsr_pkg::NVM_SWAP_BIT];
            if (nvmLoadAddr == fsr_pkg::NVM_HMI_WORD)
                hostMgmtFnEnable <= nvmLoadData[fsr_pkg::NVM_HMI_BIT];
        end
    end

    fsr_route i_fsr_route
    (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .port0Enable   (port0Enable),
        .port1Enable   (port1Enable),
        .swapSelect    (portSwapSelect),
        .port0Function (port0Function),
        .port1Function (port1Function),
        .port0Routed   (port0Routed),
        .port1Routed   (port1Routed)
    );

    // Interrupt status, write one to clear, set wins
    always_comb
    begin
        irqEvents = '0;
        irqEvents[fsr_pkg::IRQ_BIT_CHANGE] = changeEvent;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            irqStatus <= '0;
        else if (writeStrobe && wb_sel_i[0]
                 && (wb_adr_i == fsr_pkg::IRQ_STAT_ADDR))
            irqStatus <= (irqStatus
                          & ~wb_dat_i[fsr_pkg::IRQ_W-1:0]) | irqEvents;
        else
            irqStatus <= irqStatus | irqEvents;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            irqMask <= fsr_pkg::IRQ_MASK_RESET;
        else if (writeStrobe && wb_sel_i[0]
                 && (wb_adr_i == fsr_pkg::IRQ_MASK_ADDR))
            irqMask <= wb_dat_i[fsr_pkg::IRQ_W-1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(irqStatus & irqMask);
    end

    // Lower fields live in another block and read zero here
    always_comb
    begin
        statusWord = '0;
        statusWord[fsr_pkg::BIT_CHANGE]  = powerChangeFlag;
        statusWord[fsr_pkg::BIT_SWAP]    = portSwapSelect;
        statusWord[fsr_pkg::BIT_CLKGATE] = mgmtClockGated;
        statusWord[fsr_pkg::BIT_RSVD]    = 1'b0;
        statusWord[fsr_pkg::BIT_AUX4]    = fn4AuxPowerShadow;
        statusWord[fsr_pkg::BIT_HMI_EN]  = hostMgmtFnEnable;
        statusWord[fsr_pkg::LSB_FN4_LVL +: 2] =
            fnPowerLevel[2*fsr_pkg::FN4_INDEX +: 2];
    end

    always_comb
    begin
        next_readData = '0;
        case (wb_adr_i)
            fsr_pkg::FN_STATE_ADDR:
                next_readData = statusWord;
            fsr_pkg::IRQ_STAT_ADDR:
                next_readData[fsr_pkg::IRQ_W-1:0] = irqStatus;
            fsr_pkg::IRQ_MASK_ADDR:
                next_readData[fsr_pkg::IRQ_W-1:0] = irqMask;
            default:
                next_readData = '0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            wb_dat_o <= '0;
        else if (readStrobe)
            wb_dat_o <= next_readData;
        else
            wb_dat_o <= '0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_status_read;
        statusRead;
    endsequence

    sequence s_quiet_after_clear;
        !powerChangeFlag [*8];
    endsequence

    sequence s_change_ready;
        changeEvent && !holdActive && !statusRead;
    endsequence

    a_change_sets: assert property (
        s_change_ready |=> powerChangeFlag)
        else $error("change did not set flag");

    a_flag_holds: assert property (
        powerChangeFlag && !statusRead |=> powerChangeFlag)
        else $error("flag dropped without read");

    a_read_returns: assert property (
        s_status_read |=> !powerChangeFlag
        && wb_dat_o[31] == $past(powerChangeFlag))
        else $error("read did not clear flag");

    a_clear_holdoff: assert property (
        s_status_read |=> s_quiet_after_clear)
        else $error("flag set inside hold-off");

    a_pending_lands: assert property (
        s_status_read ##0 changeEvent ##1 !statusRead [*8]
        ##1 !statusRead |=> powerChangeFlag)
        else $error("held change was lost");

    a_swap_load: assert property (
        nvmLoadValid && nvmLoadAddr == fsr_pkg::NVM_SWAP_WORD
        |=> portSwapSelect == $past(nvmLoadData[0]))
        else $error("port select not loaded");

    a_swap_read: assert property (
        s_status_read |=> wb_dat_o[30] == $past(portSwapSelect))
        else $error("port select bit wrong");

    a_clock_gated: assert property (
        s_status_read |=> wb_dat_o[29] == $past(mgmtClockGated))
        else $error("clock gated bit wrong");

    a_aux_mirror: assert property (
        s_status_read |=> wb_dat_o[27] == $past(fn4AuxPowerShadow))
        else $error("aux shadow bit wrong");

    a_status_ro: assert property (
        writeStrobe && wb_adr_i == fsr_pkg::FN_STATE_ADDR && !nvmLoadValid
        |=> $stable(portSwapSelect) && $stable(hostMgmtFnEnable))
        else $error("status write changed state");

    a_hmi_load: assert property (
        nvmLoadValid && nvmLoadAddr == fsr_pkg::NVM_HMI_WORD
        |=> wb_dat_o[26] == ($past(statusRead) && $past(hostMgmtFnEnable))
        && hostMgmtFnEnable == $past(nvmLoadData[0]))
        else $error("interface enable not loaded");

    a_fn4_level: assert property (
        s_status_read |=> wb_dat_o[25:24] == $past(fnPowerLevel[9:8]))
        else $error("function 4 level wrong");

    a_reserved_zero: assert property (
        wb_ack_o |-> wb_dat_o[28] == 1'b0)
        else $error("reserved bit not zero");

    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    a_idle_data: assert property (
        !wb_ack_o |-> wb_dat_o == '0)
        else $error("read data outside ack");

    a_status_set_wins: assert property (
        changeEvent |=> irqStatus[fsr_pkg::IRQ_BIT_CHANGE])
        else $error("event lost against clear");

    a_mask_write: assert property (
        writeStrobe && wb_sel_i[0] && wb_adr_i == fsr_pkg::IRQ_MASK_ADDR
        |=> irqMask == $past(wb_dat_i[fsr_pkg::IRQ_W-1:0]))
        else $error("mask write lost");

    a_irq_level: assert property (
        (|(irqStatus & irqMask)) |=> irq)
        else $error("interrupt not raised");

endmodule : fsr_top

// ---- dv/fsr_mgmt_model.sv ----
`timescale 1ns/1ns
// Firmware side: one bus transfer per raised go, held until ack
module fsr_mgmt_model
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        go,
    input  wire logic        we,
    input  wire logic [15:0] adr,
    input  wire logic [31:0] dat,
    output logic             done,
    output logic      [31:0] rdat,
    output logic             cyc,
    output logic             stb,
    output logic             wbWe,
    output logic      [15:0] wbAdr,
    output logic      [31:0] wbDat,
    output logic      [3:0]  wbSel,
    input  wire logic [31:0] wbRdat,
    input  wire logic        ack
);
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            {cyc, stb, wbWe, done} <= 4'h0;
            wbAdr <= 16'h0000;
            wbDat <= 32'h0000_0000;
            wbSel <= 4'h0;
            rdat <= 32'h0000_0000;
        end
        else if (cyc && ack)
        begin
            // Released lines flip so stale data cannot pass
            {cyc, stb, wbWe} <= 3'h0;
            wbAdr <= ~wbAdr;
            wbDat <= ~wbDat;
            rdat <= wbRdat;
            done <= 1'b1;
        end
        else if (go && !cyc && !done)
        begin
            {cyc, stb, wbWe} <= {2'h3, we};
            wbAdr <= adr;
            wbDat <= dat;
            wbSel <= 4'hf;
        end
        else if (!go)
            done <= 1'b0;
    end
endmodule : fsr_mgmt_model

// ---- dv/tb_function_power_state_report.sv ----
`timescale 1ns/1ns
module tb_function_power_state_report;
    logic        sys_clk, resetn, cyc, stb, wbWe, ack, go, we, done;
    logic [15:0] wbAdr, adr;
    logic [31:0] wbDat, wbRdat, dat, rdat;
    logic [3:0]  wbSel;
    logic [9:0]  lvl;
    logic        gated, aux, p0En, p1En, nvmV, flag, irq, p0F, p1F, p0R, p1R;
    logic [7:0]  nvmA;
    logic [15:0] nvmD;
    int          miscompares = 0;
    int          numChecks = 0;
    int          cycles = 0;

    fsr_top i_fsr_top
    (
        .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(wbSel),
        .wb_dat_o(wbRdat), .wb_ack_o(ack), .fnPowerLevel(lvl),
        .mgmtClockGated(gated), .fn4AuxPowerShadow(aux),
        .port0Enable(p0En), .port1Enable(p1En), .nvmLoadValid(nvmV),
        .nvmLoadAddr(nvmA), .nvmLoadData(nvmD), .powerChangeFlag(flag),
        .irq(irq), .port0Function(p0F), .port1Function(p1F),
        .port0Routed(p0R), .port1Routed(p1R)
    );
    fsr_mgmt_model i_fsr_mgmt_model
    (
        .sys_clk(sys_clk), .resetn(resetn), .go(go), .we(we), .adr(adr),
        .dat(dat), .done(done), .rdat(rdat), .cyc(cyc), .stb(stb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbDat(wbDat), .wbSel(wbSel),
        .wbRdat(wbRdat), .ack(ack)
    );

    task close_out;
        if (miscompares == 0 && numChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        numChecks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_bit(input logic g, input logic e);
        chk_word({31'h0, g}, {31'h0, e});
    endtask : chk_bit

    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge sys_clk);
        go <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(negedge sys_clk); while (done !== 1'b1);
        r = rdat;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask : bus

    task automatic rd(input logic [15:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask : rd

    task automatic nvm(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        nvmV <= 1'b1;
        nvmA <= a;
        nvmD <= d;
        @(posedge sys_clk);
        nvmV <= 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : nvm

    task automatic t_fields;
        logic [31:0] r;
        rd(16'h5b30, r);
        chk_word(r, 32'h0);
        chk_bit(flag, 1'b0);
        @(posedge sys_clk);
        gated <= 1'b1;
        aux <= 1'b1;
        lvl <= 10'h200;
        // Change falls in the hold-off of the first read
        repeat (7) @(negedge sys_clk);
        chk_bit(flag, 1'b1);
        chk_bit(irq, 1'b0);
        rd(16'h5b30, r);
        chk_word(r, 32'haa00_0000);
        rd(16'h5b30, r);
        chk_word(r, 32'h2a00_0000);
        @(posedge sys_clk);
        gated <= 1'b0;
        aux <= 1'b0;
        bus(1'b1, 16'h5b30, 32'hffff_ffff, r);
        rd(16'h5b30, r);
        chk_word(r, 32'h0200_0000);
        rd(16'h5b3c, r);
        chk_word(r, 32'h0);
    endtask : t_fields

    task automatic t_route;
        logic [31:0] r;
        for (int s = 0; s < 2; s++)
        begin
            nvm(8'h21, 16'(s));
            for (int e = 1; e < 4; e++)
            begin
                @(posedge sys_clk);
                {p1En, p0En} <= 2'(e);
                repeat (3) @(negedge sys_clk);
                chk_word({30'h0, p1R, p0R}, 32'(e));
                if (e == 3)
                begin
                    chk_bit(p0F, s[0]);
                    chk_bit(p1F, !s[0]);
                end
                else if (e == 1)
                    chk_bit(p0F, 1'b0);
                else
                    chk_bit(p1F, 1'b0);
            end
        end
        nvm(8'h49, 16'h0001);
        rd(16'h5b30, r);
        chk_word(r, 32'h4600_0000);
    endtask : t_route

    task automatic t_hold;
        logic [31:0] r;
        logic        seen;
        @(posedge sys_clk);
        lvl <= 10'h001;
        // Wait out the hold-off left by the last read
        repeat (8) @(negedge sys_clk);
        rd(16'h5b30, r);
        chk_bit(r[31], 1'b1);
        @(posedge sys_clk);
        lvl <= 10'h002;
        seen = 1'b0;
        // Flag cleared at the ack edge; loop index is one more than the edges since it
        for (int i = 4; i < 14; i++)
        begin
            @(negedge sys_clk);
            if (i <= 8)
                chk_bit(flag, 1'b0);
            seen |= flag;
        end
        chk_bit(seen, 1'b1);
    endtask : t_hold

    task automatic t_irq;
        logic [31:0] r;
        bus(1'b1, 16'h5b38, 32'h1, r);
        repeat (2) @(negedge sys_clk);
        chk_bit(irq, 1'b1);
        rd(16'h5b34, r);
        chk_word(r, 32'h1);
        bus(1'b1, 16'h5b38, 32'h0, r);
        repeat (2) @(negedge sys_clk);
        chk_bit(irq, 1'b0);
        bus(1'b1, 16'h5b38, 32'h1, r);
        bus(1'b1, 16'h5b34, 32'h1, r);
        repeat (2) @(negedge sys_clk);
        chk_bit(irq, 1'b0);
        rd(16'h5b34, r);
        chk_word(r, 32'h0);
        rd(16'h5b38, r);
        chk_word(r, 32'h1);
    endtask : t_irq

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            close_out();
        end
    end

    initial
    begin
        {resetn, go, we, gated, aux, p0En, p1En, nvmV} = 8'h00;
        adr = 16'h0000;
        dat = 32'h0;
        lvl = 10'h000;
        nvmA = 8'h00;
        nvmD = 16'h0000;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_fields();
        t_route();
        t_hold();
        t_irq();
        close_out();
    end
endmodule : tb_function_power_state_report
